// ### src/pac_pkg.sv
// Constants, register map and types for the pulse accumulator and capture registers
package pac_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] CHAN_BASE_IDX = 6'h18;
    localparam logic [5:0] ACC_CTL_IDX = 6'h20;
    localparam logic [5:0] ACC_FLG_IDX = 6'h21;
    localparam logic [5:0] ACC_CNT_IDX = 6'h22;
    localparam logic [5:0] TIM_CFG_IDX = 6'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ACC_EN_BIT = 6;
    localparam int ACC_MODE_BIT = 5;
    localparam int ACC_EDGE_BIT = 4;
    localparam int CLK_SEL_LSB = 2;
    localparam int OVF_IE_BIT = 1;
    localparam int IN_IE_BIT = 0;
    localparam int OVF_FLAG_BIT = 1;
    localparam int IN_FLAG_BIT = 0;
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_EDGE_LSB = 4;
    localparam int CFG_TON_BIT = 12;
    localparam int CFG_FFC_BIT = 13;
    localparam int CFG_W = 14;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] CHAN_RESET = 16'h0000;
    localparam logic [7:0] ACC_CTL_RESET = 8'h00;
    localparam logic [15:0] ACC_CNT_RESET = 16'h0000;
    localparam logic [CFG_W-1:0] TIM_CFG_RESET = 14'h0000;

    // ----------------------------------------------------------------
    // Timer counter clock selection
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CLK_PRESCALE = 2'h0,
        CLK_ACC = 2'h1,
        CLK_ACC_256 = 2'h2,
        CLK_ACC_64K = 2'h3
    } pac_clk_sel_type;

endpackage

// ### src/pac_top.sv
// Pulse accumulator, channel 4-7 capture/compare values and their APB register file
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module pac_top import pac_pkg::*; #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Rest of the timer, same clock
    input wire logic [15:0] timer_count,
    input wire logic prescale_tick,
    input wire logic div64_tick,
    output logic counter_clock_tick,
    output logic timer_on,
    output logic [3:0] capture_compare_select,
    output logic [3:0] capture_event,
    // Channel 4-7 pins, channel 7 in bit 3
    input wire logic [3:0] chan_pin,
    // Interrupt requests
    output logic overflow_irq,
    output logic input_irq
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (ADDR_W < 8) begin : g_bad_addr
        $error("pac_top: ADDR_W must be at least 8");
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic access;
    logic [5:0] idx;
    logic [3:0] hit_chan;
    logic hit_ctl;
    logic hit_flg;
    logic hit_cnt;
    logic hit_cfg;
    logic wr_cnt;
    logic upper_zero;
    logic fast_clear;

    assign access = psel & penable;
    assign idx = paddr[7:2];
    // Shift, not slice, so the default width leaves no empty part-select
    assign upper_zero = ((paddr >> 8) == '0);
    assign hit_ctl = (idx == ACC_CTL_IDX) && upper_zero;
    assign hit_flg = (idx == ACC_FLG_IDX) && upper_zero;
    assign hit_cnt = (idx == ACC_CNT_IDX) && upper_zero;
    assign hit_cfg = (idx == TIM_CFG_IDX) && upper_zero;
    assign wr_cnt = access & pwrite & hit_cnt & (pstrb[1:0] != 2'h0);
    // Zero wait states keep software timing simple
    assign pready = 1'b1;
    assign pslverr = access & ~(hit_ctl | hit_flg | hit_cnt | hit_cfg | (hit_chan != 4'h0));

    // Every assertion in this module samples on the bus clock
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [7:0] acc_ctl_q;
    logic [CFG_W-1:0] tim_cfg_q;
    logic acc_en;
    logic acc_mode;
    logic acc_edge;
    logic fast_flag_clear;
    pac_clk_sel_type clk_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ctl_q <= ACC_CTL_RESET;
        end else if (access && pwrite && hit_ctl && pstrb[0]) begin
            acc_ctl_q <= {1'b0, pwdata[6:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tim_cfg_q <= TIM_CFG_RESET;
        end else if (access && pwrite && hit_cfg) begin
            if (pstrb[0]) begin
                tim_cfg_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                tim_cfg_q[CFG_W-1:8] <= pwdata[CFG_W-1:8];
            end
        end
    end

    assign acc_en = acc_ctl_q[ACC_EN_BIT];
    assign acc_mode = acc_ctl_q[ACC_MODE_BIT];
    assign acc_edge = acc_ctl_q[ACC_EDGE_BIT];
    assign clk_sel = pac_clk_sel_type'(acc_ctl_q[CLK_SEL_LSB +: 2]);
    assign timer_on = tim_cfg_q[CFG_TON_BIT];
    assign fast_flag_clear = tim_cfg_q[CFG_FFC_BIT];
    assign capture_compare_select = tim_cfg_q[CFG_SEL_LSB +: 4];
    assign fast_clear = fast_flag_clear & access & hit_cnt;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------------------------------
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 4'h0;
        end else begin
            pin_meta_q <= chan_pin;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign pin_rise = pin_sync_q & ~pin_prev_q;
    assign pin_fall = ~pin_sync_q & pin_prev_q;

    // ----------------------------------------------------------------
    // Channel capture/compare values
    // ----------------------------------------------------------------
    logic [15:0] chan_val_q [4];

    for (genvar i = 0; i < 4; i++) begin : g_chan
        localparam logic [5:0] MY_IDX = CHAN_BASE_IDX + 6'(i);
        logic [1:0] edge_cfg;
        assign edge_cfg = tim_cfg_q[CFG_EDGE_LSB + 2*i +: 2];
        assign hit_chan[i] = (idx == MY_IDX) && upper_zero;
        assign capture_event[i] = ~capture_compare_select[i]
            & ((edge_cfg[0] & pin_rise[i]) | (edge_cfg[1] & pin_fall[i]));

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chan_val_q[i] <= CHAN_RESET;
            // Capture never meets a write: writes need compare mode, which masks capture
            end else if (capture_event[i]) begin
                chan_val_q[i] <= timer_count;
            end else if (access && pwrite && hit_chan[i] && capture_compare_select[i]) begin
                // Lanes are independent, so high-then-low byte writes compose
                if (pstrb[0]) begin
                    chan_val_q[i][7:0] <= pwdata[7:0];
                end
                if (pstrb[1]) begin
                    chan_val_q[i][15:8] <= pwdata[15:8];
                end
            end
        end

        AST_CAPTURE: assert property (capture_event[i] |=>
            chan_val_q[i] == $past(timer_count))
            else $error("capture did not store the counter");
        AST_WRITE_IGNORED: assert property (
            access && pwrite && hit_chan[i] && !capture_compare_select[i]
            && !capture_event[i] |=> $stable(chan_val_q[i]))
            else $error("write landed during input capture");
        AST_RESET_ZERO: assert property ($rose(presetn) |->
            chan_val_q[i] == CHAN_RESET)
            else $error("channel value not zero after reset");
        AST_CHAN_WRITE: assert property (
            access && pwrite && hit_chan[i] && capture_compare_select[i]
            && pstrb[1:0] == 2'h3 |=> chan_val_q[i] == $past(pwdata[15:0]))
            else $error("compare-mode write not stored");
    end

    // ----------------------------------------------------------------
    // Accumulator input and clock
    // ----------------------------------------------------------------
    logic pa_in;
    logic sel_edge;
    logic gate_active;
    logic acc_tick;
    logic in_set;
    logic [15:0] acc_cnt_q;
    logic ovf_set;
    logic half_wrap;

    assign pa_in = pin_sync_q[3];
    // Trailing gate edge and counted event edge share the same polarity
    assign sel_edge = acc_edge ? pin_rise[3] : pin_fall[3];
    assign gate_active = acc_edge ? ~pa_in : pa_in;
    assign acc_tick = acc_en & (acc_mode
        ? (gate_active & div64_tick & timer_on)
        : sel_edge);
    assign in_set = acc_en & sel_edge;
    // A count write in the wrap cycle wins, so that wrap is never flagged
    assign ovf_set = acc_tick & ~wr_cnt & (acc_cnt_q == 16'hFFFF);
    assign half_wrap = acc_tick & (acc_cnt_q[7:0] == 8'hFF);

    // Combinational so a new select acts on the very next cycle
    always_comb begin
        counter_clock_tick = prescale_tick;
        if (acc_en) begin
            case (clk_sel)
                CLK_PRESCALE: counter_clock_tick = prescale_tick;
                CLK_ACC: counter_clock_tick = acc_tick;
                CLK_ACC_256: counter_clock_tick = half_wrap;
                CLK_ACC_64K: counter_clock_tick = ovf_set;
                default: counter_clock_tick = prescale_tick;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Accumulator count
    // ----------------------------------------------------------------
    // A software write in the same cycle as a count wins; that edge is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_cnt_q <= ACC_CNT_RESET;
        end else if (wr_cnt) begin
            if (pstrb[0]) begin
                acc_cnt_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                acc_cnt_q[15:8] <= pwdata[15:8];
            end
        end else if (acc_tick) begin
            acc_cnt_q <= acc_cnt_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Flags and interrupt requests
    // ----------------------------------------------------------------
    logic ovf_flag_q;
    logic in_flag_q;
    logic flg_wr;

    assign flg_wr = access & pwrite & hit_flg & pstrb[0];

    // Hardware set wins over any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_flag_q <= 1'b0;
        end else if (ovf_set) begin
            ovf_flag_q <= 1'b1;
        end else if (fast_clear || (flg_wr && pwdata[OVF_FLAG_BIT])) begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_flag_q <= 1'b0;
        end else if (in_set) begin
            in_flag_q <= 1'b1;
        end else if (fast_clear || (flg_wr && pwdata[IN_FLAG_BIT])) begin
            in_flag_q <= 1'b0;
        end
    end

    assign overflow_irq = ovf_flag_q & acc_ctl_q[OVF_IE_BIT];
    assign input_irq = in_flag_q & acc_ctl_q[IN_IE_BIT];

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        // Unmapped indices and unused bits read as zero
        prdata = 32'h0000_0000;
        if (hit_ctl) begin
            prdata[7:0] = acc_ctl_q;
        end
        if (hit_flg) begin
            prdata[1:0] = {ovf_flag_q, in_flag_q};
        end
        if (hit_cnt) begin
            prdata[15:0] = acc_cnt_q;
        end
        if (hit_cfg) begin
            prdata[CFG_W-1:0] = tim_cfg_q;
        end
        for (int k = 0; k < 4; k++) begin
            if (hit_chan[k]) begin
                prdata[15:0] = chan_val_q[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    AST_RUN_TIMER_OFF: assert property (
        acc_en && !acc_mode && sel_edge && !timer_on && !wr_cnt
        |=> acc_cnt_q == $past(acc_cnt_q) + 16'h0001)
        else $error("event count stalled with timer off");
    AST_DISABLED_HOLDS: assert property (
        !acc_en && !wr_cnt |=> $stable(acc_cnt_q))
        else $error("count moved while accumulator disabled");
    AST_EVENT_POLARITY: assert property (
        acc_en && !acc_mode && !wr_cnt
        && !(acc_edge ? pin_rise[3] : pin_fall[3]) |=> $stable(acc_cnt_q))
        else $error("count moved on the wrong edge");
    AST_GATED_COUNT: assert property (
        acc_en && acc_mode && timer_on && div64_tick && !wr_cnt
        && (pa_in != acc_edge) |=> acc_cnt_q == $past(acc_cnt_q) + 16'h0001)
        else $error("gated tick not counted");
    AST_GATED_TIMER_OFF: assert property (
        acc_en && acc_mode && !timer_on && !wr_cnt [*2] |-> $stable(acc_cnt_q))
        else $error("gated count moved with timer off");
    AST_DIV256: assert property (
        acc_en && clk_sel == CLK_ACC_256 && counter_clock_tick && !wr_cnt
        |=> acc_cnt_q[7:0] == 8'h00)
        else $error("divide-by-256 tick not on low byte wrap");
    AST_PRESCALE_FORCED: assert property (
        !acc_en |-> counter_clock_tick == prescale_tick)
        else $error("counter clock not prescaler while disabled");
    AST_SELECT_IMMEDIATE: assert property (
        access && pwrite && hit_ctl && pstrb[0] && pwdata[ACC_EN_BIT]
        && pwdata[3:2] == 2'h0 |=> counter_clock_tick == prescale_tick)
        else $error("clock select change was deferred");
    AST_OVF_IRQ: assert property (
        ovf_set && acc_ctl_q[OVF_IE_BIT] && !(access && pwrite && hit_ctl)
        |=> overflow_irq)
        else $error("overflow request missing");
    AST_IN_IRQ: assert property (
        in_set && acc_ctl_q[IN_IE_BIT] && !(access && pwrite && hit_ctl)
        |=> input_irq)
        else $error("input request missing");
    AST_FAST_CLEAR: assert property (
        fast_clear && !ovf_set && !in_set |=> !ovf_flag_q && !in_flag_q)
        else $error("fast clear left a flag set");
    AST_OVF_SET: assert property (ovf_set |=> ovf_flag_q && acc_cnt_q == 16'h0000)
        else $error("wrap did not set overflow");
    AST_IN_SET: assert property (in_set |=> in_flag_q)
        else $error("edge did not set input flag");
    AST_CNT_WRITE: assert property (
        wr_cnt && pstrb[1:0] == 2'h3 |=> acc_cnt_q == $past(pwdata[15:0]))
        else $error("count write not stored");
    AST_SYNC_DELAY: assert property (
        pin_rise[3] |-> $past(chan_pin[3], 2) && !$past(chan_pin[3], 3))
        else $error("input edge skipped the synchroniser");
    AST_FLAG_KEEP: assert property (
        flg_wr && !pwdata[OVF_FLAG_BIT] && !fast_clear && ovf_flag_q |=> ovf_flag_q)
        else $error("zero write cleared overflow");
    AST_IN_FLAG_KEEP: assert property (
        flg_wr && !pwdata[IN_FLAG_BIT] && !fast_clear && in_flag_q |=> in_flag_q)
        else $error("zero write cleared input flag");
    AST_ACC_CLOCK: assert property (
        acc_en && clk_sel == CLK_ACC |-> counter_clock_tick == acc_tick)
        else $error("accumulator clock not routed to the counter");
    AST_DIV64K: assert property (
        acc_en && clk_sel == CLK_ACC_64K && counter_clock_tick |=> acc_cnt_q == 16'h0000)
        else $error("divide-by-65536 tick not on count wrap");
    AST_FLAG_UPPER_ZERO: assert property (
        access && hit_flg |-> prdata[31:2] == 30'h0000_0000)
        else $error("flag register upper bits not zero");

    COV_EVENT_WRAP: cover property (acc_en && !acc_mode && ovf_set);
    COV_GATED_TRAIL: cover property (acc_en && acc_mode && in_set);
    COV_CAPTURE: cover property (capture_event[3]);
    COV_FAST_CLEAR: cover property (fast_clear && in_flag_q);
    COV_DIV256: cover property (acc_en && clk_sel == CLK_ACC_256 && counter_clock_tick);

endmodule

// ### bench/pac_pulse_src.sv
// Pulse source model standing on the shared channel-7 pin
`timescale 1ns/1ps
module pac_pulse_src (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command from the bench
    input wire logic go,
    input wire logic [7:0] cnt,
    input wire logic lvl,
    // Pin side
    output logic pin,
    output logic busy
);
    // ------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------
    logic [7:0] left_q;
    logic [2:0] ph_q;
    // Each pulse leaves the idle level for four cycles, then rests four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 8'h00;
            ph_q <= 3'h0;
        end else if (go && left_q == 8'h00) begin
            left_q <= cnt;
            ph_q <= 3'h0;
        end else if (left_q != 8'h00) begin
            ph_q <= ph_q + 3'h1;
            if (ph_q == 3'h7) begin
                left_q <= left_q - 8'h01;
            end
        end
    end
    assign busy = (left_q != 8'h00);
    // Four cycles keeps every pulse wider than two bus clocks
    assign pin = (busy && ph_q < 3'h4) ? ~lvl : lvl;
endmodule

// ### bench/test_pac_top.sv
// Self-checking bench for the pulse accumulator and capture register block
`timescale 1ns/1ps
module test_pac_top;
    import pac_pkg::*;
    localparam logic [7:0] A_CH = {CHAN_BASE_IDX, 2'b00};
    localparam logic [7:0] A_CTL = {ACC_CTL_IDX, 2'b00};
    localparam logic [7:0] A_FLG = {ACC_FLG_IDX, 2'b00};
    localparam logic [7:0] A_CNT = {ACC_CNT_IDX, 2'b00};
    localparam logic [7:0] A_CFG = {TIM_CFG_IDX, 2'b00};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0] pstrb = 4'h0, ccs, cap_ev, pins;
    logic [15:0] tcnt = 16'h0000, cap;
    logic pre_tick = 1'b0, d64_tick = 1'b0, go = 1'b0, lvl = 1'b0, rerr;
    logic [7:0] npls = 8'h00;
    logic [2:0] cp_lo = 3'h0;
    logic pready, pslverr, src_pin, busy, cc_tick, ton, ovf_irq, in_irq;
    int failures = 0, cmp_count = 0, cc_n = 0;
    // Channel 7 carries only the pulse source; no output logic drives the pin
    assign pins = {src_pin, cp_lo};
    always #5 pclk = ~pclk;
    always @(posedge pclk) tcnt <= tcnt + 16'h0001;
    always @(posedge pclk) if (cc_tick === 1'b1) cc_n <= cc_n + 1;
    pac_top u_pac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_count(tcnt), .prescale_tick(pre_tick),
        .div64_tick(d64_tick), .counter_clock_tick(cc_tick), .timer_on(ton),
        .capture_compare_select(ccs), .capture_event(cap_ev), .chan_pin(pins),
        .overflow_irq(ovf_irq), .input_irq(in_irq));
    pac_pulse_src u_pac_pulse_src (.pclk(pclk), .presetn(presetn), .go(go), .cnt(npls),
        .lvl(lvl), .pin(src_pin), .busy(busy));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask
    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        chk(name, rdat, exp);
    endtask
    task automatic pulses(input logic [7:0] n);
        @(posedge pclk); go <= 1'b1; npls <= n;
        @(posedge pclk); go <= 1'b0;
        // Busy rises only after the model has taken the command
        @(posedge pclk);
        for (int i = 0; i < 3000 && busy === 1'b1; i++) @(posedge pclk);
        repeat (6) @(posedge pclk);
    endtask
    task automatic gate(input int n);
        lvl <= 1'b1;
        repeat (6) @(posedge pclk);
        repeat (n) begin
            @(posedge pclk); d64_tick <= 1'b1;
            @(posedge pclk); d64_tick <= 1'b0;
        end
        lvl <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rchk("chan_reset", A_CH + 8'(4 * i), 32'h0);
        rchk("ctl_reset", A_CTL, 32'h0);
        rchk("cnt_reset", A_CNT, 32'h0);
        apb(1'b0, 8'hFC, 32'h0, 4'hF);
        chk("unmapped_err", 32'(rerr), 32'h1);
        chk("unmapped_data", rdat, 32'h0);
    endtask
    task automatic t_capture();
        wr(A_CFG, 32'h0010);
        // Two synchroniser stages and the edge detect: latch on the third edge
        cp_lo[0] <= 1'b1;
        cap = tcnt + 16'h0003;
        repeat (3) @(posedge pclk);
        chk("capture_event", 32'(cap_ev), 32'h1);
        rchk("capture_value", A_CH, 32'(cap));
        wr(A_CH, 32'h1234);
        rchk("write_in_capture", A_CH, 32'(cap));
        cp_lo[0] <= 1'b0;
        wr(A_CFG, 32'h0001);
        @(posedge pclk);
        chk("select_out", 32'(ccs), 32'h1);
        wr(A_CH, 32'h1234);
        rchk("write_in_compare", A_CH, 32'h1234);
        apb(1'b1, A_CH, 32'h5600, 4'h2);
        rchk("high_lane_write", A_CH, 32'h5634);
        apb(1'b1, A_CH, 32'h00AB, 4'h1);
        rchk("low_lane_write", A_CH, 32'h56AB);
        wr(A_CFG, 32'h0000);
    endtask
    task automatic t_event();
        wr(A_CTL, 32'h51);
        pulses(8'd5);
        rchk("rising_count", A_CNT, 32'd5);
        rchk("input_flag", A_FLG, 32'h01);
        chk("input_irq_on", 32'(in_irq), 32'h1);
    endtask
    task automatic t_ovf();
        int base;
        wr(A_CTL, 32'h4E);
        wr(A_CNT, 32'hFFFE);
        wr(A_FLG, 32'h03);
        base = cc_n;
        pulses(8'd2);
        rchk("falling_wrap", A_CNT, 32'h0);
        chk("div64k_ticks", 32'(cc_n - base), 32'd1);
        rchk("ovf_flag", A_FLG, 32'h03);
        chk("ovf_irq_on", 32'(ovf_irq), 32'h1);
        chk("input_irq_off", 32'(in_irq), 32'h0);
        wr(A_FLG, 32'h00);
        rchk("flag_write_zero", A_FLG, 32'h03);
        wr(A_FLG, 32'h02);
        rchk("ovf_clear", A_FLG, 32'h01);
        chk("ovf_irq_off", 32'(ovf_irq), 32'h0);
    endtask
    task automatic t_fast();
        wr(A_FLG, 32'h00);
        wr(A_CFG, 32'h2000);
        rchk("fast_cnt", A_CNT, 32'h0);
        rchk("fast_clear", A_FLG, 32'h0);
        wr(A_CFG, 32'h0000);
    endtask
    task automatic t_gated();
        wr(A_CTL, 32'h60);
        gate(3);
        rchk("gated_timer_off", A_CNT, 32'h0);
        rchk("trailing_flag", A_FLG, 32'h01);
        wr(A_CFG, 32'h1000);
        @(posedge pclk);
        chk("timer_on", 32'(ton), 32'h1);
        wr(A_FLG, 32'h01);
        gate(3);
        rchk("gated_count", A_CNT, 32'd3);
    endtask
    task automatic t_clksel();
        int base;
        wr(A_CTL, 32'hFF);
        rchk("ctl_readback", A_CTL, 32'h7F);
        wr(A_CTL, 32'h04);
        @(posedge pclk); pre_tick <= 1'b1;
        #1 chk("disabled_prescale", 32'(cc_tick), 32'h1);
        @(posedge pclk); pre_tick <= 1'b0;
        wr(A_CTL, 32'h44);
        @(posedge pclk); pre_tick <= 1'b1;
        #1 chk("sel_acc_no_prescale", 32'(cc_tick), 32'h0);
        @(posedge pclk); pre_tick <= 1'b0;
        base = cc_n;
        pulses(8'd2);
        chk("acc_clock_ticks", 32'(cc_n - base), 32'd2);
        wr(A_CTL, 32'h48);
        wr(A_CNT, 32'h00FE);
        base = cc_n;
        pulses(8'd2);
        chk("acc256_ticks", 32'(cc_n - base), 32'd1);
        rchk("acc256_count", A_CNT, 32'h0100);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_capture();
        t_event();
        t_ovf();
        t_fast();
        t_gated();
        t_clksel();
        summarize();
    end
    // Whole sequence needs a few hundred cycles; this leaves wide margin
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule
